// file: rtl/lcd_frame_clock_and_drive.sv
// Overview of operation
// - pin count code enables segments 0 to last
// - segments above range return to port
// - frame rate bits 7 and 3 read zero
// - tap code selects prescaler divide N
// - divider divides tap output by code plus one
// - prescaled clock is source over N times D
// - frame spans K times N times D ticks
// - drivers on for selected time per transition
// - on-time capped at half prescaled period
// - static duty or blank forces half period
// - source select picks system or oscillator clock
// - duty code picks static, half, third, quarter
// - full drive override keeps drivers always on
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module lcd_frame_clock_and_drive
    import lcd_frame_pkg::*;
#(
    parameter longint SYS_HZ = 200000000,
    parameter longint OSC_HZ = 32768
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic [7:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic osc_clk_i, // asynchronous oscillator level
    output logic lcd_enable_o, // controller enabled
    output logic lcd_clock_source_select_o, // 1 = oscillator source
    output logic [1:0] duty_select_o, // duty code
    output logic lcd_prescaled_clock_o, // prescaled clock level
    output logic lcd_prescaled_tick_o, // start of prescaled period
    output logic frame_start_o, // start of a frame
    output logic blank_active_o, // blanking in force this frame
    output logic [3:0] contrast_voltage_select_o, // contrast latched at frame
    output logic driver_on_o, // segment and common drivers on
    output logic [SEG_COUNT-1:0] segment_output_en_o, // 1 = lcd owns pin
    output logic [COM_COUNT-1:0] common_output_en_o // 1 = lcd owns pin
);

    // software registers
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic [7:0] frr_q;
    logic [7:0] dcr_q;
    logic [7:0] rdata_q;

    // timing state
    logic osc_q;
    logic [11:0] presc_q;
    logic [2:0] div_q;
    logic [PHASE_W-1:0] phase_q;
    logic [2:0] fpos_q;
    logic ps_tick_q;
    logic frame_q;
    logic psclk_q;
    logic blank_q;
    logic [3:0] contrast_q;

    // decoded fields
    logic enable;
    logic blank_req;
    logic src_sel;
    logic [1:0] duty;
    logic [2:0] pm;
    logic [2:0] ps;
    logic [2:0] cd;
    logic [2:0] dc;
    logic full_drive;
    logic [3:0] cc;

    assign enable = ctrl_q[CTRL_EN_BIT];
    assign blank_req = ctrl_q[CTRL_BL_BIT];
    assign src_sel = mode_q[MODE_CS_BIT];
    assign duty = mode_q[MODE_MUX_LSB +: 2];
    assign pm = mode_q[MODE_PM_LSB +: 3];
    assign ps = frr_q[FRR_PS_LSB +: 3];
    assign cd = frr_q[FRR_CD_LSB +: 3];
    assign dc = dcr_q[DCR_DC_LSB +: 3];
    assign full_drive = dcr_q[DCR_MDT_BIT];
    assign cc = dcr_q[DCR_CC_LSB +: 4];

    // register port decode
    logic wr_ctrl;
    logic wr_mode;
    logic wr_frr;
    logic wr_dcr;

    assign wr_ctrl = wr_i && (addr_i == CTRL_ADDR);
    assign wr_mode = wr_i && (addr_i == MODE_ADDR);
    assign wr_frr = wr_i && (addr_i == FRR_ADDR);
    assign wr_dcr = wr_i && (addr_i == DCR_ADDR);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_q <= REG_RESET;
            mode_q <= REG_RESET;
            frr_q <= REG_RESET;
            dcr_q <= REG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata_i & CTRL_RW_MASK;
            end
            if (wr_mode) begin
                mode_q <= wdata_i & MODE_RW_MASK;
            end
            if (wr_frr) begin
                frr_q <= wdata_i & FRR_RW_MASK;
            end
            if (wr_dcr) begin
                dcr_q <= wdata_i & DCR_RW_MASK;
            end
        end
    end

    // status view of the timing state
    logic [7:0] status;
    logic drive_on;

    always_comb begin
        status = '0;
        status[ST_BLANK_BIT] = blank_q;
        status[ST_DRIVE_BIT] = drive_on;
        status[ST_PSCLK_BIT] = psclk_q;
        status[ST_FPOS_LSB +: 3] = fpos_q;
    end

    logic [7:0] rd_mux;

    assign rd_mux = (addr_i == STATUS_ADDR) ? status :
                    (addr_i == CTRL_ADDR) ? ctrl_q :
                    (addr_i == MODE_ADDR) ? mode_q :
                    (addr_i == FRR_ADDR) ? (frr_q & FRR_RW_MASK) :
                    (addr_i == DCR_ADDR) ? dcr_q : 8'h00;

    // data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_q <= REG_RESET;
        end else begin
            rdata_q <= rd_i ? rd_mux : REG_RESET;
        end
    end

    assign rdata_o = rdata_q;

    // source clock: the oscillator pin is sampled, so it must run well
    // below half the system clock for every edge to be seen
    logic osc_rise;
    logic src_tick;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_clk_i;
        end
    end

    assign osc_rise = osc_clk_i && !osc_q;
    assign src_tick = src_sel ? osc_rise : 1'b1;

    // prescaler tap, clock divider and frame position
    logic [11:0] presc_last;
    logic presc_wrap;
    logic div_wrap;
    logic ps_edge;
    logic [2:0] k_last;
    logic frame_edge;

    assign presc_last = tap_last(ps);
    assign presc_wrap = src_tick && (presc_q >= presc_last);
    assign div_wrap = presc_wrap && (div_q >= cd);
    assign ps_edge = div_wrap;
    assign k_last = (duty == DUTY_THIRD) ? K_LAST_THIRD : K_LAST_DEFAULT;
    assign frame_edge = ps_edge && (fpos_q >= k_last);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !enable) begin
            presc_q <= '0;
            div_q <= '0;
            fpos_q <= '0;
        end else begin
            if (presc_wrap) begin
                presc_q <= '0;
            end else if (src_tick) begin
                presc_q <= presc_q + 1'b1;
            end
            if (div_wrap) begin
                div_q <= '0;
            end else if (presc_wrap) begin
                div_q <= div_q + 1'b1;
            end
            if (frame_edge) begin
                fpos_q <= '0;
            end else if (ps_edge) begin
                fpos_q <= fpos_q + 1'b1;
            end
        end
    end

    // half a prescaled period in source ticks: N * D / 2
    logic [PHASE_W-1:0] n_val;
    logic [PHASE_W:0] period;
    logic [PHASE_W-1:0] half;

    assign n_val = PHASE_W'({1'b0, presc_last} + 13'h0001);
    // one bit wider than the phase counter: N = 4096 with D = 8 needs it
    assign period = {1'b0, n_val} * ({13'h0000, cd} + 16'h0001);
    assign half = period[PHASE_W:1];

    // prescaled clock level: high for the first half of each period
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !enable) begin
            phase_q <= '0;
            psclk_q <= 1'b0;
            ps_tick_q <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            ps_tick_q <= ps_edge;
            frame_q <= frame_edge;
            if (ps_edge) begin
                phase_q <= '0;
                psclk_q <= 1'b1;
            end else if (src_tick) begin
                phase_q <= phase_q + 1'b1;
                if (phase_q + 1'b1 >= half) begin
                    psclk_q <= 1'b0;
                end
            end
        end
    end

    // blanking and contrast take effect at the next frame boundary
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !enable) begin
            blank_q <= 1'b0;
            contrast_q <= '0;
        end else if (frame_edge) begin
            blank_q <= blank_req;
            contrast_q <= cc;
        end
    end

    // driver on-time
    logic [TIME_W-1:0] nominal;
    logic force_half;

    assign nominal = src_sel ? drive_ticks(dc, OSC_HZ) : drive_ticks(dc, SYS_HZ);
    assign force_half = (dc == DC_HALF_CODE) || (duty == DUTY_STATIC) || blank_q;

    lcd_drive_timer u_drive (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .active_i(enable),
        .start_i(ps_edge),
        .src_tick_i(src_tick),
        .full_i(full_drive),
        .force_half_i(force_half),
        .nominal_i(nominal),
        .half_i({{(TIME_W-PHASE_W){1'b0}}, half}),
        .drive_on_o(drive_on)
    );

    // pin ownership
    logic [4:0] s_last;
    logic [SEG_COUNT-1:0] seg_q;
    logic [COM_COUNT-1:0] com_q;

    assign s_last = seg_last(pm);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            seg_q <= '0;
            com_q <= '0;
        end else begin
            for (int i = 0; i < SEG_COUNT; i++) begin
                seg_q[i] <= enable && (5'(i) <= s_last);
            end
            for (int j = 0; j < COM_COUNT; j++) begin
                com_q[j] <= enable && (2'(j) <= duty);
            end
        end
    end

    assign lcd_enable_o = enable;
    assign lcd_clock_source_select_o = src_sel;
    assign duty_select_o = duty;
    assign lcd_prescaled_clock_o = psclk_q;
    assign lcd_prescaled_tick_o = ps_tick_q;
    assign frame_start_o = frame_q;
    assign blank_active_o = blank_q;
    assign contrast_voltage_select_o = contrast_q;
    assign driver_on_o = drive_on;
    assign segment_output_en_o = seg_q;
    assign common_output_en_o = com_q;

endmodule : lcd_frame_clock_and_drive

// file: rtl/lcd_frame_pkg.sv
package lcd_frame_pkg;

    // register map, byte addresses on the 8-bit register port
    localparam logic [7:0] STATUS_ADDR = 8'he3;
    localparam logic [7:0] CTRL_ADDR = 8'he4;
    localparam logic [7:0] MODE_ADDR = 8'he5;
    localparam logic [7:0] FRR_ADDR = 8'he6;
    localparam logic [7:0] DCR_ADDR = 8'he7;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CTRL_RW_MASK = 8'h81;
    localparam logic [7:0] MODE_RW_MASK = 8'hf7;
    localparam logic [7:0] FRR_RW_MASK = 8'h77;
    localparam logic [7:0] DCR_RW_MASK = 8'hff;

    // field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_BL_BIT = 0;
    localparam int MODE_CS_BIT = 7;
    localparam int MODE_MUX_LSB = 4;
    localparam int MODE_PM_LSB = 0;
    localparam int FRR_PS_LSB = 4;
    localparam int FRR_CD_LSB = 0;
    localparam int DCR_DC_LSB = 5;
    localparam int DCR_MDT_BIT = 4;
    localparam int DCR_CC_LSB = 0;
    localparam int ST_BLANK_BIT = 7;
    localparam int ST_DRIVE_BIT = 6;
    localparam int ST_PSCLK_BIT = 5;
    localparam int ST_FPOS_LSB = 0;

    localparam int SEG_COUNT = 25;
    localparam int COM_COUNT = 4;
    localparam int PHASE_W = 15;
    localparam int TIME_W = 18;

    typedef enum logic [1:0] {
        DUTY_STATIC,
        DUTY_HALF,
        DUTY_THIRD,
        DUTY_QUARTER
    } duty_e;

    // last value of the frame position counter: K-1
    localparam logic [2:0] K_LAST_DEFAULT = 3'h7;
    localparam logic [2:0] K_LAST_THIRD = 3'h5;

    localparam logic [2:0] DC_HALF_CODE = 3'h7;
    localparam longint US_PER_S = 1000000;
    localparam longint DRIVE_US [7] = '{300, 70, 150, 450, 575, 850, 1150};

    // prescaler tap N minus one
    function automatic logic [11:0] tap_last(input logic [2:0] ps);
        case (ps)
            3'h0: tap_last = 12'h00f;
            3'h1: tap_last = 12'h03f;
            3'h2: tap_last = 12'h07f;
            3'h3: tap_last = 12'h0ff;
            3'h4: tap_last = 12'h1ff;
            3'h5: tap_last = 12'h3ff;
            3'h6: tap_last = 12'h7ff;
            default: tap_last = 12'hfff;
        endcase
    endfunction : tap_last

    // highest segment index owned by the lcd for a pin count code
    function automatic logic [4:0] seg_last(input logic [2:0] pm);
        case (pm)
            3'h0: seg_last = 5'h0c;
            3'h1: seg_last = 5'h0e;
            3'h2: seg_last = 5'h10;
            3'h3: seg_last = 5'h12;
            3'h4: seg_last = 5'h14;
            3'h5: seg_last = 5'h16;
            3'h6: seg_last = 5'h17;
            default: seg_last = 5'h18;
        endcase
    endfunction : seg_last

    // nominal on-time in source ticks, rounded up
    function automatic logic [TIME_W-1:0] drive_ticks(input logic [2:0] dc, input longint hz);
        longint t;
        t = 0;
        if (dc != DC_HALF_CODE) begin
            t = (DRIVE_US[dc] * hz + US_PER_S - 1) / US_PER_S;
        end
        drive_ticks = TIME_W'(t);
    endfunction : drive_ticks

endpackage : lcd_frame_pkg

// file: rtl/lcd_drive_timer.sv
`timescale 1ns/100ps
module lcd_drive_timer
    import lcd_frame_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic active_i, // lcd enabled
    input wire logic start_i, // prescaled clock edge, a voltage transition
    input wire logic src_tick_i, // one source clock tick
    input wire logic full_i, // drivers on all the time
    input wire logic force_half_i, // use half a prescaled period
    input wire logic [TIME_W-1:0] nominal_i, // nominal time in source ticks
    input wire logic [TIME_W-1:0] half_i, // half prescaled period in ticks
    output logic drive_on_o // drivers on
);

    logic [TIME_W-1:0] remain_q;
    logic drive_q;
    logic [TIME_W-1:0] capped;
    logic [TIME_W-1:0] load;

    assign capped = (nominal_i < half_i) ? nominal_i : half_i;
    assign load = force_half_i ? half_i : capped;
    assign drive_on_o = drive_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !active_i) begin
            remain_q <= '0;
            drive_q <= 1'b0;
        end else if (start_i) begin
            remain_q <= load;
            drive_q <= full_i || (load != '0);
        end else if (src_tick_i && remain_q != '0) begin
            remain_q <= remain_q - 1'b1;
            drive_q <= full_i || (remain_q > 1);
        end else begin
            drive_q <= full_i || (remain_q != '0);
        end
    end

endmodule : lcd_drive_timer

// file: dv/lcd_frame_checker.sv
`timescale 1ns/100ps
module lcd_frame_checker
    import lcd_frame_pkg::*;
(
    input wire logic clk_sys_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic [7:0] addr_i, // address
    input wire logic rd_i, // read strobe
    input wire logic [7:0] rdata_o, // read data
    input wire logic lcd_enable_o, // enable
    input wire logic [1:0] duty_select_o, // duty code
    input wire logic lcd_prescaled_tick_o, // period tick
    input wire logic frame_start_o, // frame pulse
    input wire logic driver_on_o, // drivers on
    input wire logic [SEG_COUNT-1:0] segment_output_en_o, // segment owner
    input wire logic [COM_COUNT-1:0] common_output_en_o // common owner
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [SEG_COUNT-1:0] seg_next;
    // a contiguous run from bit 0 turns into a single bit when incremented, or into zero when all 25 are set
    assign seg_next = segment_output_en_o + 1'b1;

    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its slot");
    a_frr_reserved: assert property ($past(rd_i) && $past(addr_i) == FRR_ADDR
        |-> (rdata_o & 8'h88) == 8'h00) else $error("reserved frame rate bits set");
    a_seg_release: assert property (!lcd_enable_o && !$past(lcd_enable_o)
        |-> segment_output_en_o == '0) else $error("segments kept while off");
    a_seg_range: assert property (segment_output_en_o != '0
        |-> &segment_output_en_o[12:0] && (segment_output_en_o & seg_next) == '0)
        else $error("segment range not contiguous");
    a_com_duty: assert property (lcd_enable_o && $past(lcd_enable_o) && $stable(duty_select_o)
        |-> common_output_en_o == {duty_select_o == 2'h3, duty_select_o[1],
        |duty_select_o, 1'b1}) else $error("common pins do not match duty");
    a_tick_gap: assert property (lcd_prescaled_tick_o
        |=> (!lcd_prescaled_tick_o)[*8] ##1 (!lcd_prescaled_tick_o)[*7])
        else $error("prescaled ticks too close");
    a_frame_tick: assert property (frame_start_o |-> lcd_prescaled_tick_o)
        else $error("frame start off a prescaled edge");
    a_stop_ticks: assert property (!lcd_enable_o
        |=> !lcd_prescaled_tick_o && !frame_start_o) else $error("ticks while disabled");
    a_drive_idle: assert property (!lcd_enable_o [*2] |-> !driver_on_o)
        else $error("drivers on while disabled");
endmodule : lcd_frame_checker

bind lcd_frame_clock_and_drive lcd_frame_checker chk_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .lcd_enable_o(lcd_enable_o), .duty_select_o(duty_select_o),
    .lcd_prescaled_tick_o(lcd_prescaled_tick_o), .frame_start_o(frame_start_o),
    .driver_on_o(driver_on_o), .segment_output_en_o(segment_output_en_o),
    .common_output_en_o(common_output_en_o)
);

// file: dv/lcd_glass_model.sv
`timescale 1ns/100ps
module lcd_glass_model
    import lcd_frame_pkg::*;
#(
    parameter int OSC_HALF = 4
) (
    input wire logic clk_sys_i, // system clock
    input wire logic driver_on_i, // drivers on
    input wire logic [COM_COUNT-1:0] com_en_i, // common pins owned
    output logic osc_clk_o, // crystal level
    output logic [15:0] on_cnt_o // cycles the glass was driven
);
    int phase = 0;
    initial osc_clk_o = 1'b0;
    initial on_cnt_o = 16'h0000;
    // the crystal runs free, independent of the lcd state
    always @(posedge clk_sys_i) begin
        phase <= (phase == OSC_HALF - 1) ? 0 : phase + 1;
        if (phase == OSC_HALF - 1) begin
            osc_clk_o <= !osc_clk_o;
        end
        if (driver_on_i && com_en_i[0]) begin
            on_cnt_o <= on_cnt_o + 16'h0001;
        end
    end
endmodule : lcd_glass_model

// file: dv/test_lcd_frame_clock_and_drive.sv
`timescale 1ns/100ps
module test_lcd_frame_clock_and_drive
    import lcd_frame_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic osc_clk_i;
    logic [7:0] rdata_o;
    logic en, sel, psclk, tick, frame, blank, drv;
    logic [1:0] duty;
    logic [3:0] cc;
    logic [SEG_COUNT-1:0] seg_en;
    logic [COM_COUNT-1:0] com_en;
    logic [15:0] on_cnt;
    int bad_count = 0;
    int checked = 0;
    localparam int TAP_N [8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
    localparam int ON_US [8] = '{300, 70, 150, 450, 575, 850, 1150, 512};
    localparam int SEG_LAST [8] = '{12, 14, 16, 18, 20, 22, 23, 24};

    always #2.5 clk_sys_i = ~clk_sys_i;

    lcd_frame_clock_and_drive #(.SYS_HZ(1000000), .OSC_HZ(62500)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_clk_i(osc_clk_i),
        .lcd_enable_o(en), .lcd_clock_source_select_o(sel), .duty_select_o(duty),
        .lcd_prescaled_clock_o(psclk), .lcd_prescaled_tick_o(tick),
        .frame_start_o(frame), .blank_active_o(blank), .contrast_voltage_select_o(cc),
        .driver_on_o(drv), .segment_output_en_o(seg_en), .common_output_en_o(com_en)
    );
    lcd_glass_model #(.OSC_HALF(4)) glass_u (
        .clk_sys_i(clk_sys_i), .driver_on_i(drv), .com_en_i(com_en),
        .osc_clk_o(osc_clk_i), .on_cnt_o(on_cnt)
    );

    task report_and_stop;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd_reg

    // bounded waits, sampling after the edge has settled
    task wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1 n++;
        end while (tick !== 1'b1 && n < 20000);
    endtask : wait_tick

    task wait_frame(output int n);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1 n++;
        end while (frame !== 1'b1 && n < 20000);
    endtask : wait_frame

    task t_regs;
        logic [7:0] d;
        logic [7:0] msk [4];
        msk = '{8'h81, 8'hf7, 8'h77, 8'hff};
        rd_reg(STATUS_ADDR, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd_reg(CTRL_ADDR + 8'(i), d);
            chk(d, 8'h00);
            wr_reg(CTRL_ADDR + 8'(i), 8'hff);
            rd_reg(CTRL_ADDR + 8'(i), d);
            chk(d, msk[i]);
        end
        wr_reg(8'he8, 8'hff);
        rd_reg(8'he8, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(CTRL_ADDR + 8'(i), 8'h00);
        end
    endtask : t_regs

    task t_pins;
        wr_reg(CTRL_ADDR, 8'h80);
        for (int pm = 0; pm < 8; pm++) begin
            wr_reg(MODE_ADDR, 8'h30 | 8'(pm));
            repeat (3) @(posedge clk_sys_i);
            chk(seg_en, (32'h1 << (SEG_LAST[pm] + 1)) - 1);
        end
        for (int d = 0; d < 4; d++) begin
            wr_reg(MODE_ADDR, 8'(d << 4) | 8'h07);
            repeat (3) @(posedge clk_sys_i);
            chk(com_en, (32'h1 << (d + 1)) - 1);
            chk({en, sel, duty}, {2'b10, 2'(d)});
        end
        wr_reg(CTRL_ADDR, 8'h00);
        repeat (3) @(posedge clk_sys_i);
        chk({seg_en, com_en}, 0);
    endtask : t_pins

    task setup(input logic [7:0] frr, input logic [7:0] mode);
        wr_reg(CTRL_ADDR, 8'h00);
        wr_reg(FRR_ADDR, frr);
        wr_reg(MODE_ADDR, mode);
        wr_reg(CTRL_ADDR, 8'h80);
    endtask : setup

    task t_rate;
        int n;
        for (int ps = 0; ps < 8; ps++) begin
            setup(8'(ps << 4), 8'h30);
            wait_tick(n);
            // counting starts at the edge that enables, so the first period is full length
            chk(n, TAP_N[ps]);
            wait_tick(n);
            chk(n, TAP_N[ps]);
        end
        for (int cd = 1; cd < 8; cd++) begin
            setup(8'(cd), 8'h30);
            wait_tick(n);
            wait_tick(n);
            chk(n, 16 * (cd + 1));
        end
        setup(8'h01, 8'h20);
        wait_frame(n);
        wait_frame(n);
        chk(n, 6 * 16 * 2);
        setup(8'h01, 8'h30);
        wait_frame(n);
        wait_frame(n);
        chk(n, 8 * 16 * 2);
        // prescaled clock high for half of N * D = 32 ticks
        chk(psclk, 1'b1);
        repeat (15) @(posedge clk_sys_i);
        #1 chk(psclk, 1'b1);
        @(posedge clk_sys_i);
        #1 chk(psclk, 1'b0);
        // crystal period is 8 system cycles
        setup(8'h00, 8'hb0);
        wait_tick(n);
        wait_tick(n);
        chk(n, 16 * 8);
        chk(sel, 1'b1);
    endtask : t_rate

    task meas(input logic [7:0] ctrl, input logic [7:0] mode, input logic [7:0] dcr,
              input int exp);
        int n;
        logic [15:0] a;
        setup(8'h50, mode);
        wr_reg(DCR_ADDR, dcr);
        wr_reg(CTRL_ADDR, ctrl);
        // blanking only takes hold at a frame boundary
        if (ctrl[CTRL_BL_BIT]) begin
            wait_frame(n);
        end
        wait_tick(n);
        a = on_cnt;
        wait_tick(n);
        a = on_cnt - a;
        chk(a, exp);
        chk({blank, cc}, ctrl[CTRL_BL_BIT] ? {1'b1, dcr[3:0]} : 5'h00);
    endtask : meas

    task t_drive;
        for (int c = 0; c < 8; c++) begin
            meas(8'h80, 8'h30, 8'(c << 5), (ON_US[c] > 512) ? 512 : ON_US[c]);
        end
        meas(8'h80, 8'h30, 8'h30, 1024);
        meas(8'h80, 8'h00, 8'h20, 512);
        meas(8'h81, 8'h30, 8'h2a, 512);
    endtask : t_drive

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_pins();
        t_rate();
        t_drive();
        report_and_stop();
    end

    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
endmodule : test_lcd_frame_clock_and_drive
